// ---- src/utfr_consts.svh ----
// Constants of the under-temperature fault responder: offsets, field positions, codes and reset values.
// Assumes inclusion by the delay timer and responder modules only.
// Functional notes
// - Response code 00 keeps the output running with no interruption while the fault is present.
// - Response code 01 keeps running for the programmed delay, then applies the retry setting if the fault remains.
// - Response code 10 disables the output at once and then follows the retry setting.
// - Response code 11 disables the output until the fault is cleared, with no restart attempts.
// - A latched fault clears on a status bit clear, a clear-all command, reset, or an off-then-on command.
// - Retry code 000 makes no restart attempt and keeps the output off until the fault is cleared.
// - Retry codes 001 to 011 give one to three attempts, after which the output stays off until cleared.
// - Restart attempts start separated by the delay count times the fault's delay unit.
// - Delay codes 0 to 7 stand for 1, 2, 4, 8, 16, 32, 64 and 128 delay units.
// - Retry codes 100 to 110 give four to six attempts and 111 retries until commanded off.
`ifndef UTFR_CONSTS_SVH
`define UTFR_CONSTS_SVH

`define UTFR_ACTION_CODE   8'h54
`define UTFR_ACTION_RESET  8'hC0
`define UTFR_RESP_MSB      7
`define UTFR_RESP_LSB      6
`define UTFR_RETRY_MSB     5
`define UTFR_RETRY_LSB     3
`define UTFR_DELAY_MSB     2
`define UTFR_DELAY_LSB     0
`define UTFR_RETRY_NONE    3'h0
`define UTFR_RETRY_ALWAYS  3'h7
`define UTFR_UNITS_ONE     8'h01

`endif

// ---- src/utfr_pkg.sv ----
// Types of the under-temperature fault responder.
// Assumes nothing of its surroundings.
package utfr_pkg;
    typedef enum logic [1:0] {
        RESP_IGNORE = 2'h0,
        RESP_DELAY  = 2'h1,
        RESP_RETRY  = 2'h2,
        RESP_LATCH  = 2'h3
    } utfr_resp_type;

    typedef enum logic [3:0] {
        ST_RUN  = 4'h1,
        ST_HOLD = 4'h2,
        ST_WAIT = 4'h4,
        ST_LOCK = 4'h8
    } utfr_state_type;
endpackage

// ---- src/utfr_delay_timer.sv ----
// Delay timer counting delay-unit ticks, 2**code units per run.
// Assumes unit_tick is a one-cycle pulse on mclk, one per delay time unit.
`timescale 1ns/1ps
`include "utfr_consts.svh"
module utfr_delay_timer (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       start,
    input  wire logic       stop,
    input  wire logic [2:0] code,
    input  wire logic       unit_tick,
    output logic            done
);
    logic [7:0] remaining;
    logic [7:0] next_remaining;
    logic       active;
    logic       next_active;
    logic       next_done;

    always_comb begin
        next_remaining = remaining;
        next_active    = active;
        next_done      = 1'b0;
        if (stop) begin
            next_active    = 1'b0;
            next_remaining = 8'h00;
        end else if (start) begin
            next_active    = 1'b1;
            next_remaining = `UTFR_UNITS_ONE << code;
        end else if (active && unit_tick) begin
            if (remaining == `UTFR_UNITS_ONE) begin
                next_active    = 1'b0;
                next_done      = 1'b1;
                next_remaining = 8'h00;
            end else begin
                next_remaining = remaining - `UTFR_UNITS_ONE;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            remaining <= 8'h00;
            active    <= 1'b0;
            done      <= 1'b0;
        end else if (ce) begin
            remaining <= next_remaining;
            active    <= next_active;
            done      <= next_done;
        end
    end
endmodule

// ---- src/utfr_responder.sv ----
// Under-temperature fault response: action register, retry sequencing and output enable.
// Assumes fault, unit_tick, clear strobes and command writes come from logic on mclk;
// the on/off control pin is asynchronous and is synchronised here.
`timescale 1ns/1ps
`include "utfr_consts.svh"
module utfr_responder
    import utfr_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic       ctrl_pin,
    input  wire logic       operation_on,
    input  wire logic       fault,
    input  wire logic       unit_tick,
    input  wire logic       clear_bit,
    input  wire logic       clear_all,
    input  wire logic       cmd_wr,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] cmd_data,
    output logic      [7:0] action,
    output logic            out_enable,
    output logic            fault_latched,
    output logic            locked,
    output logic            retrying,
    output logic      [2:0] attempts
);
    logic           rst_q1;
    logic           rst_n;
    logic           ctrl_q1;
    logic           ctrl_q2;
    logic           on_prev;
    logic           on_cmd;
    logic           on_rise;
    logic           clr;
    utfr_resp_type  resp;
    logic [2:0]     retries;
    logic [2:0]     delay_code;
    utfr_state_type state;
    utfr_state_type next_state;
    logic [2:0]     next_attempts;
    logic [7:0]     next_action;
    logic           next_out_enable;
    logic           next_latched;
    logic           tmr_start;
    logic           tmr_stop;
    logic           tmr_done;
    logic           give_up;

    // Reset released through two flops; kept running while ce is low so reset never hangs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    assign on_cmd     = ctrl_q2 & operation_on;
    assign on_rise    = on_cmd & ~on_prev;
    assign clr        = clear_bit | clear_all | on_rise;
    assign resp       = utfr_resp_type'(action[`UTFR_RESP_MSB:`UTFR_RESP_LSB]);
    assign retries    = action[`UTFR_RETRY_MSB:`UTFR_RETRY_LSB];
    assign delay_code = action[`UTFR_DELAY_MSB:`UTFR_DELAY_LSB];
    // Out of attempts: none allowed, or a finite limit already used up
    assign give_up    = (retries == `UTFR_RETRY_NONE) ||
                        ((retries != `UTFR_RETRY_ALWAYS) && (attempts >= retries));

    utfr_delay_timer u_timer (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .start     (tmr_start),
        .stop      (tmr_stop),
        .code      (delay_code),
        .unit_tick (unit_tick),
        .done      (tmr_done)
    );

    always_comb begin
        next_action = action;
        if (cmd_wr && (cmd_code == `UTFR_ACTION_CODE)) begin
            next_action = cmd_data;
        end
    end

    always_comb begin
        next_state    = state;
        next_attempts = attempts;
        tmr_start     = 1'b0;
        tmr_stop      = 1'b0;
        // Set wins over clear so a fault in the clearing cycle stays visible
        next_latched  = fault ? 1'b1 : (clr ? 1'b0 : fault_latched);
        if (!on_cmd || clr) begin
            // Commanded off or cleared: start over with a fresh sequence
            next_state    = ST_RUN;
            next_attempts = 3'h0;
            tmr_stop      = 1'b1;
        end else begin
            unique case (state)
                ST_RUN: begin
                    if (fault) begin
                        unique case (resp)
                            RESP_IGNORE: next_state = ST_RUN;
                            RESP_DELAY: begin
                                next_state = ST_HOLD;
                                tmr_start  = 1'b1;
                            end
                            RESP_RETRY: begin
                                next_state = give_up ? ST_LOCK : ST_WAIT;
                                tmr_start  = ~give_up;
                            end
                            RESP_LATCH: next_state = ST_LOCK;
                        endcase
                    end
                end
                ST_HOLD: begin
                    if (tmr_done) begin
                        if (fault) begin
                            next_state = give_up ? ST_LOCK : ST_WAIT;
                            tmr_start  = ~give_up;
                        end else begin
                            next_state = ST_RUN;
                        end
                    end
                end
                ST_WAIT: begin
                    if (tmr_done) begin
                        // Restart attempt; a fault seen again in run counts it as failed
                        next_state = ST_RUN;
                        if (attempts != `UTFR_RETRY_ALWAYS) begin
                            next_attempts = attempts + 3'h1;
                        end
                    end
                end
                ST_LOCK: next_state = ST_LOCK;
            endcase
        end
        next_out_enable = on_cmd && !clr && ((next_state == ST_RUN) || (next_state == ST_HOLD));
        if (on_cmd && clr) begin
            next_out_enable = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q1       <= 1'b0;
            ctrl_q2       <= 1'b0;
            on_prev       <= 1'b0;
            action        <= `UTFR_ACTION_RESET;
            state         <= ST_RUN;
            attempts      <= 3'h0;
            out_enable    <= 1'b0;
            fault_latched <= 1'b0;
            locked        <= 1'b0;
            retrying      <= 1'b0;
        end else if (ce) begin
            ctrl_q1       <= ctrl_pin;
            ctrl_q2       <= ctrl_q1;
            on_prev       <= on_cmd;
            action        <= next_action;
            state         <= next_state;
            attempts      <= next_attempts;
            out_enable    <= next_out_enable;
            fault_latched <= next_latched;
            locked        <= (next_state == ST_LOCK);
            retrying      <= (next_state == ST_WAIT);
        end
    end

    // Unit ticks the timer really counts while waiting to restart
    logic [7:0] wait_ticks;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ticks <= 8'h00;
        end else if (ce) begin
            if (state != ST_WAIT) begin
                wait_ticks <= 8'h00;
            end else if (unit_tick && !tmr_done) begin
                wait_ticks <= wait_ticks + 8'h01;
            end
        end
    end

    logic live;
    assign live = ce && on_cmd && !clr;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    ignore_keeps_run_a: assert property (live && state == ST_RUN && fault && resp == RESP_IGNORE
        |=> state == ST_RUN && out_enable)
        else $error("ignored fault disturbed the output");
    hold_stays_on_a: assert property (state == ST_HOLD && $past(state) == ST_HOLD && $past(ce)
        |-> out_enable)
        else $error("output dropped during the run-on delay");
    hold_end_cut_a: assert property (live && state == ST_HOLD && tmr_done && fault
        |=> !out_enable)
        else $error("fault at end of delay did not shut down");
    retry_cuts_out_a: assert property (live && state == ST_RUN && fault && resp == RESP_RETRY
        |=> !out_enable ##0 (locked || retrying))
        else $error("disable-and-retry did not shut down");
    latch_locks_a: assert property (live && state == ST_RUN && fault && resp == RESP_LATCH
        |=> locked && !out_enable)
        else $error("latch response did not lock");
    clear_resets_a: assert property (ce && clr |=> !locked && attempts == 3'h0 && !retrying)
        else $error("clear did not restart the sequence");
    no_retry_lock_a: assert property (live && state == ST_RUN && fault && resp == RESP_RETRY
        && retries == `UTFR_RETRY_NONE |=> locked)
        else $error("zero retries did not lock");
    limit_locks_a: assert property (live && state == ST_RUN && fault && resp == RESP_RETRY
        && retries != `UTFR_RETRY_ALWAYS && attempts >= retries |=> locked)
        else $error("attempt limit did not lock");
    wait_spacing_a: assert property (live && state == ST_WAIT && tmr_done
        |-> wait_ticks == (`UTFR_UNITS_ONE << delay_code))
        else $error("restart spacing differs from delay units");
    endless_retry_a: assert property (live && state == ST_RUN && fault && resp == RESP_RETRY
        && retries == `UTFR_RETRY_ALWAYS |=> retrying && !locked)
        else $error("continuous retry gave up");

    lock_seen_c: cover property (live && state == ST_RUN && fault ##1 locked);
    restart_seen_c: cover property (state == ST_WAIT && tmr_done && live ##1 out_enable);
    hold_end_c: cover property (state == ST_HOLD && tmr_done && live);
    clear_lock_c: cover property (locked && ce && clr);
endmodule

// ---- tb/utfr_host_model.sv ----
// Host side model: writes the response register and issues fault clear events.
// Assumes the bench calls its tasks from one process, away from reset.
`timescale 1ns/1ps
module utfr_host_model (
    input  wire logic       mclk,
    output logic            cmd_wr,
    output logic      [7:0] cmd_code,
    output logic      [7:0] cmd_data,
    output logic            clear_bit,
    output logic            clear_all
);
    initial begin
        cmd_wr    = 1'b0;
        cmd_code  = 8'h00;
        cmd_data  = 8'h00;
        clear_bit = 1'b0;
        clear_all = 1'b0;
    end

    // Data is inverted after the write so a stale byte is never mistaken for a new one
    task automatic write_reg(input logic [7:0] code, input logic [7:0] data);
        @(posedge mclk);
        cmd_wr   <= 1'b1;
        cmd_code <= code;
        cmd_data <= data;
        @(posedge mclk);
        cmd_wr   <= 1'b0;
        cmd_data <= ~data;
    endtask

    task automatic clear(input logic all);
        @(posedge mclk);
        clear_all <= all;
        clear_bit <= !all;
        @(posedge mclk);
        clear_all <= 1'b0;
        clear_bit <= 1'b0;
    endtask
endmodule

// ---- tb/under_temp_fault_responder_tb.sv ----
// Self-checking bench of the under-temperature fault responder.
// Assumes one 100 MHz clock; delay units are fed by hand as unit_tick pulses.
`timescale 1ns/1ps
module under_temp_fault_responder_tb;
    logic       mclk = 1'b0;
    logic       nrst = 1'b0;
    logic       ce = 1'b1;
    logic       ctrl_pin = 1'b1;
    logic       operation_on = 1'b1;
    logic       fault = 1'b0;
    logic       unit_tick = 1'b0;
    logic       cmd_wr, clear_bit, clear_all;
    logic [7:0] cmd_code, cmd_data, action;
    logic       out_enable, fault_latched, locked, retrying;
    logic [2:0] attempts;
    int         num_errors = 0;
    int         comparisons = 0;
    int         cycles = 0;

    utfr_host_model host_u (.mclk(mclk), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_data(cmd_data),
        .clear_bit(clear_bit), .clear_all(clear_all));
    utfr_responder dut_u (.mclk(mclk), .nrst(nrst), .ce(ce), .ctrl_pin(ctrl_pin),
        .operation_on(operation_on), .fault(fault), .unit_tick(unit_tick), .clear_bit(clear_bit),
        .clear_all(clear_all), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_data(cmd_data),
        .action(action), .out_enable(out_enable), .fault_latched(fault_latched), .locked(locked),
        .retrying(retrying), .attempts(attempts));

    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            conclude();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk);
            unit_tick <= 1'b1;
            @(posedge mclk);
            unit_tick <= 1'b0;
        end
    endtask

    task automatic set_fault(input logic v);
        @(posedge mclk);
        fault <= v;
    endtask

    // Fault removed, new setting written, and a clear so every run starts fresh
    task automatic fresh(input logic [7:0] setting);
        set_fault(1'b0);
        host_u.write_reg(8'h54, setting);
        host_u.clear(1'b1);
        cyc(3);
        check(out_enable, 1'b1, "output on");
        check(attempts, 3'h0, "attempts");
    endtask

    task automatic test_register;
        check(action, 8'hC0, "reset value");
        host_u.write_reg(8'h54, 8'h5A);
        cyc(1);
        check(action, 8'h5A, "written value");
        host_u.write_reg(8'h53, 8'h00);
        @(posedge mclk);
        ce <= 1'b0;
        host_u.write_reg(8'h54, 8'h11);
        @(posedge mclk);
        ce <= 1'b1;
        cyc(1);
        check(action, 8'h5A, "ignored writes");
        $display("test register done");
    endtask

    task automatic test_ignore;
        fresh(8'h3F);
        set_fault(1'b1);
        tick(200);
        cyc(2);
        check(out_enable, 1'b1, "ignore keeps output");
        check(fault_latched, 1'b1, "fault seen");
        $display("test ignore done");
    endtask

    task automatic test_latch(input int how);
        fresh(8'hFF);
        set_fault(1'b1);
        cyc(2);
        check({locked, out_enable}, 2'b10, "latched off");
        tick(130);
        cyc(2);
        check({locked, attempts}, 4'h8, "no restarts");
        set_fault(1'b0);
        if (how < 2) begin
            host_u.clear(how[0]);
        end else begin
            // Off through the command, or through the pin, which needs two more edges to sync
            @(posedge mclk);
            if (how == 2) begin
                operation_on <= 1'b0;
            end else begin
                ctrl_pin <= 1'b0;
            end
            cyc(4);
            check(out_enable, 1'b0, "commanded off");
            @(posedge mclk);
            operation_on <= 1'b1;
            ctrl_pin     <= 1'b1;
            cyc(6);
        end
        cyc(2);
        check({locked, out_enable, fault_latched}, 3'b010, "cleared");
        $display("test latch clear %0d done", how);
    endtask

    task automatic test_delay(input logic [2:0] d);
        fresh({2'b01, 3'b000, d});
        set_fault(1'b1);
        tick((1 << d) - 1);
        cyc(3);
        check(out_enable, 1'b1, "running during delay");
        tick(1);
        cyc(3);
        check({out_enable, locked}, 2'b01, "off after delay");
        $display("test delay %0d done", d);
    endtask

    // Run-on delay that the fault does not outlast ends in run; one that it outlasts goes on to retry
    task automatic test_delay_retry;
        fresh({2'b01, 3'b001, 3'b001});
        set_fault(1'b1);
        tick(1);
        set_fault(1'b0);
        tick(1);
        cyc(3);
        check({out_enable, locked, retrying}, 3'b100, "fault gone at delay end");
        set_fault(1'b1);
        tick(2);
        cyc(3);
        check({out_enable, retrying, attempts}, 5'h08, "retry after delay");
        $display("test delay retry done");
    endtask

    task automatic test_retry(input logic [2:0] r, input logic [2:0] d);
        int n;
        bit seen;
        n = (r == 3'h7) ? 9 : r;
        fresh({2'b10, r, d});
        set_fault(1'b1);
        cyc(2);
        check(out_enable, 1'b0, "disabled at once");
        for (int i = 0; i < n; i++) begin
            tick((1 << d) - 1);
            cyc(2);
            check({out_enable, retrying}, 2'b01, "off between attempts");
            tick(1);
            seen = 0;
            for (int k = 0; k < 6 && !seen; k++) begin
                cyc(1);
                seen = (out_enable === 1'b1);
            end
            check(seen, 1'b1, "restart attempt");
            check(attempts, 8'((i < 7) ? i + 1 : 7), "attempt count");
            cyc(2);
        end
        if (r != 3'h7) begin
            tick(4);
            cyc(2);
            check({locked, out_enable}, 2'b10, "off until cleared");
        end else begin
            @(posedge mclk);
            operation_on <= 1'b0;
            cyc(4);
            check({out_enable, retrying}, 2'b00, "stopped by off");
            @(posedge mclk);
            operation_on <= 1'b1;
        end
        $display("test retry %0d delay %0d done", r, d);
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        cyc(10);
        test_register();
        test_ignore();
        for (int h = 0; h < 4; h++) begin
            test_latch(h);
        end
        for (int d = 0; d < 8; d++) begin
            test_delay(d[2:0]);
        end
        test_delay_retry();
        for (int r = 0; r < 8; r++) begin
            test_retry(r[2:0], 3'h0);
        end
        test_retry(3'h2, 3'h2);
        conclude();
    end
endmodule
